// ===== verilog/epiu_pkg.sv
// Operation
// - An enabled line requests from pin activity even while the pin drives out.
// - Two independent lines, each sensing falling edge, rising edge, any change or low level.
// - Enabled level-mode line requests continuously while its pin stays low.
// - Edge recognition uses the running I/O clock; none while it is stopped.
// - Low-level detection works without the I/O clock and wakes from any sleep.
// - I/O clock stops in every sleep mode but idle; edges wake only idle.
// - Power-down level wake samples the level twice on the watchdog clock.
// - Watchdog clock pacing the wake sampling has a one microsecond period.
// - Wake when the level passes double sampling or persists through start-up.
// - Level gone before start-up ends: wake completes, no level interrupt.
// - Sense code: 00 low level, 01 any change, 10 falling, 11 rising.
// - Request taken only with line enable and global enable; own vector per line.
// - Flag sets on event, clears on handler entry or write one; zero in level mode.
// - Edge and change modes catch pin pulses longer than one clock period.
package epiu_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_SENSE = 8'h00;
  localparam logic [7:0] ADDR_ENABLE = 8'h04;
  localparam logic [7:0] ADDR_FLAG = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_SLEEP = 8'h10;
  localparam logic [7:0] ADDR_PIN = 8'h14;
  localparam logic [7:0] ADDR_ISTAT = 8'h18;
  localparam logic [7:0] ADDR_IMASK = 8'h1c;
  // Field positions
  localparam int EN_A_BIT = 6;
  localparam int FLAG_A_BIT = 6;
  localparam int GIE_BIT = 7;
  localparam int SLEEP_GO_BIT = 0;
  localparam int SLEEP_MODE_LO = 1;
  localparam int SLEEPING_BIT = 3;
  localparam int PIN_OUT_LO = 0;
  localparam int PIN_OE_LO = 4;
  localparam int PIN_LEVEL_LO = 8;
  localparam int ISTAT_WAKE_BIT = 2;
  // Sense codes
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_ANY = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;
  // Sleep modes
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_POWER_DOWN = 2'h1;
  localparam logic [1:0] MODE_POWER_SAVE = 2'h2;
  localparam logic [1:0] MODE_STANDBY = 2'h3;
  // Reset values
  localparam logic [3:0] SENSE_RESET = 4'h0;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [2:0] IMASK_RESET = 3'h0;
  // Timing
  localparam int MCLK_PERIOD_NS = 5;
  localparam int WD_PERIOD_NS = 1000;
  localparam int WD_TICK_CYC = WD_PERIOD_NS / MCLK_PERIOD_NS;
  localparam logic [7:0] WD_TICK_LAST = 8'(WD_TICK_CYC - 1);
  // Start-up lengths in watchdog ticks, one per fuse setting
  localparam logic [11:0] START_TICKS_0 = 12'h004;
  localparam logic [11:0] START_TICKS_1 = 12'h010;
  localparam logic [11:0] START_TICKS_2 = 12'h040;
  localparam logic [11:0] START_TICKS_3 = 12'h100;
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_SAMPLE, ST_STARTUP} epiu_wake_e;
endpackage : epiu_pkg

// ===== verilog/epiu_line_det.sv
`timescale 1ns/10ps
`default_nettype none
module epiu_line_det (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_pin,
  input wire logic [1:0] i_sense,
  input wire logic i_io_run,
  input wire logic i_clear,
  output logic o_flag,
  output logic o_level_low,
  output logic o_event
);
  logic sync1;
  logic sync2;
  logic prev;
  logic flag;
  wire rise = sync2 & ~prev;
  wire fall = ~sync2 & prev;
  wire level_mode = (i_sense == epiu_pkg::SENSE_LOW);
  // Edge decode per sense code, gated by the I/O clock being live
  wire edge_hit = (i_sense == epiu_pkg::SENSE_ANY) ? (rise | fall) :
                  (i_sense == epiu_pkg::SENSE_FALL) ? fall :
                  (i_sense == epiu_pkg::SENSE_RISE) ? rise : 1'b0;
  wire event_now = edge_hit & i_io_run;
  // Set beats clear so an event in the clearing cycle survives
  wire next_flag = level_mode ? 1'b0 : (event_now | (flag & ~i_clear));

  // Two-stage synchronizer, then one history stage for edges
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      prev <= 1'b1;
    end else begin
      sync1 <= i_pin;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  // Flag and one-cycle event pulse
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag <= 1'b0;
      o_event <= 1'b0;
    end else begin
      flag <= next_flag;
      o_event <= event_now & ~level_mode;
    end
  end

  assign o_flag = flag;
  // Level path needs no I/O clock, so it serves deep sleep
  assign o_level_low = ~sync2;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  rise_flag_a: assert property (
    (i_sense == epiu_pkg::SENSE_RISE) && i_io_run && rise ##1 (i_sense == epiu_pkg::SENSE_RISE)
    |-> flag) else $error("rising edge did not set flag");
  no_edge_stop_a: assert property (
    !i_io_run && !flag |=> !flag) else $error("flag set while io clock stopped");
  level_clear_a: assert property (
    level_mode |=> !flag) else $error("flag visible in level mode");
  fall_ignored_a: assert property (
    (i_sense == epiu_pkg::SENSE_RISE) && fall && !flag && !i_clear |=> !flag)
    else $error("falling edge set flag in rising mode");
  cov_any_c: cover property ((i_sense == epiu_pkg::SENSE_ANY) && fall ##1 flag);
endmodule : epiu_line_det
`default_nettype wire

// ===== verilog/epiu_top.sv
// Our own choices: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module epiu_top #(
  parameter logic [11:0] P_START_TICKS_0 = epiu_pkg::START_TICKS_0,
  parameter logic [11:0] P_START_TICKS_1 = epiu_pkg::START_TICKS_1,
  parameter logic [11:0] P_START_TICKS_2 = epiu_pkg::START_TICKS_2,
  parameter logic [11:0] P_START_TICKS_3 = epiu_pkg::START_TICKS_3
) (
  input wire logic I_MCLK,
  input wire logic I_RESET_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_EXT_LINE_A_PIN,
  input wire logic I_EXT_LINE_B_PIN,
  output logic O_EXT_LINE_A_PIN,
  output logic O_EXT_LINE_A_PIN_OE,
  output logic O_EXT_LINE_B_PIN,
  output logic O_EXT_LINE_B_PIN_OE,
  input wire logic [1:0] I_STARTUP_TIME_FUSES,
  input wire logic [1:0] I_HANDLER_ENTER,
  output logic [1:0] O_LINE_REQ,
  output logic O_VECTOR_VALID,
  output logic O_VECTOR_LINE,
  output logic O_IO_CLK_RUN,
  output logic O_SLEEPING,
  output logic O_WAKE,
  output logic O_IRQ
);
  logic pready;
  logic [3:0] sense;
  logic [1:0] line_en;
  logic gie;
  logic [1:0] sleep_mode;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  logic [2:0] istat;
  logic [2:0] imask;
  logic [1:0] flag;
  logic [1:0] level_low;
  logic [1:0] det_event;
  logic [7:0] wd_cnt;
  logic [11:0] start_cnt;
  logic commit;
  epiu_pkg::epiu_wake_e state;
  epiu_pkg::epiu_wake_e next_state;
  logic next_commit;
  logic next_wake;

  // APB phase decode; slave answers in the first access cycle
  wire apb_setup = I_PSEL & ~I_PENABLE & ~pready;
  wire apb_done = I_PSEL & I_PENABLE & pready;
  wire wr_done = apb_done & I_PWRITE;
  wire rd_done = apb_done & ~I_PWRITE;
  wire sel_sense = (I_PADDR == epiu_pkg::ADDR_SENSE);
  wire sel_enable = (I_PADDR == epiu_pkg::ADDR_ENABLE);
  wire sel_flag = (I_PADDR == epiu_pkg::ADDR_FLAG);
  wire sel_status = (I_PADDR == epiu_pkg::ADDR_STATUS);
  wire sel_sleep = (I_PADDR == epiu_pkg::ADDR_SLEEP);
  wire sel_pin = (I_PADDR == epiu_pkg::ADDR_PIN);
  wire sel_istat = (I_PADDR == epiu_pkg::ADDR_ISTAT);
  wire sel_imask = (I_PADDR == epiu_pkg::ADDR_IMASK);
  wire addr_hit = sel_sense | sel_enable | sel_flag | sel_status | sel_sleep | sel_pin |
                  sel_istat | sel_imask;

  // Pin side: the pad loops back, so driven values are sensed as well
  wire [1:0] pin_in = {I_EXT_LINE_B_PIN, I_EXT_LINE_A_PIN};
  wire [1:0] sensed = (pin_oe & pin_out) | (~pin_oe & pin_in);

  // Read mux
  wire [31:0] rd_value =
    sel_sense ? {28'h0000000, sense} :
    sel_enable ? (32'(line_en) << epiu_pkg::EN_A_BIT) :
    sel_flag ? (32'(flag) << epiu_pkg::FLAG_A_BIT) :
    sel_status ? (32'(gie) << epiu_pkg::GIE_BIT) :
    sel_sleep ? ((32'(sleep_mode) << epiu_pkg::SLEEP_MODE_LO) |
                 (32'(state != epiu_pkg::ST_RUN) << epiu_pkg::SLEEPING_BIT)) :
    sel_pin ? ((32'(pin_out) << epiu_pkg::PIN_OUT_LO) | (32'(pin_oe) << epiu_pkg::PIN_OE_LO) |
               (32'({~level_low}) << epiu_pkg::PIN_LEVEL_LO)) :
    sel_istat ? {29'h00000000, istat} :
    sel_imask ? {29'h00000000, imask} : 32'h00000000;

  // Write strobes and clears
  wire sleep_go = wr_done & sel_sleep & I_PWDATA[epiu_pkg::SLEEP_GO_BIT];
  wire [1:0] flag_w1c = {2{wr_done & sel_flag}} & I_PWDATA[epiu_pkg::FLAG_A_BIT +: 2];
  wire [1:0] flag_clear = flag_w1c | I_HANDLER_ENTER;
  wire istat_clear = rd_done & sel_istat;
  // Mode after this edge, so the clock flag follows a mode written with the sleep command
  wire [1:0] next_mode = (wr_done & sel_sleep) ? I_PWDATA[epiu_pkg::SLEEP_MODE_LO +: 2] :
                         sleep_mode;

  // APB answer registers, loaded during setup so outputs come from flops
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      pready <= 1'b0;
      O_PRDATA <= 32'h00000000;
      O_PSLVERR <= 1'b0;
    end else begin
      pready <= apb_setup;
      O_PRDATA <= apb_setup & ~I_PWRITE ? rd_value : 32'h00000000;
      O_PSLVERR <= apb_setup & ~addr_hit;
    end
  end
  assign O_PREADY = pready;

  // Software registers
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      sense <= epiu_pkg::SENSE_RESET;
      line_en <= 2'h0;
      gie <= 1'b0;
      sleep_mode <= epiu_pkg::MODE_RESET;
      pin_out <= 2'h0;
      pin_oe <= 2'h0;
      imask <= epiu_pkg::IMASK_RESET;
    end else if (wr_done) begin
      if (sel_sense) sense <= I_PWDATA[3:0];
      if (sel_enable) line_en <= I_PWDATA[epiu_pkg::EN_A_BIT +: 2];
      if (sel_status) gie <= I_PWDATA[epiu_pkg::GIE_BIT];
      if (sel_sleep) sleep_mode <= I_PWDATA[epiu_pkg::SLEEP_MODE_LO +: 2];
      if (sel_pin) pin_out <= I_PWDATA[epiu_pkg::PIN_OUT_LO +: 2];
      if (sel_pin) pin_oe <= I_PWDATA[epiu_pkg::PIN_OE_LO +: 2];
      if (sel_imask) imask <= I_PWDATA[2:0];
    end
  end

  // I/O clock runs while awake, or asleep in idle only
  wire io_run = (state == epiu_pkg::ST_RUN) |
                ((state == epiu_pkg::ST_SLEEP) & (sleep_mode == epiu_pkg::MODE_IDLE));

  // One detector per line
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_line
      epiu_line_det u_det (
        .i_clk(I_MCLK),
        .i_rst_n(I_RESET_N),
        .i_pin(sensed[gi]),
        .i_sense(sense[2*gi +: 2]),
        .i_io_run(io_run),
        .i_clear(flag_clear[gi]),
        .o_flag(flag[gi]),
        .o_level_low(level_low[gi]),
        .o_event(det_event[gi])
      );
    end
  endgenerate

  // Per-line request terms
  wire [1:0] level_mode = {sense[3:2] == epiu_pkg::SENSE_LOW, sense[1:0] == epiu_pkg::SENSE_LOW};
  wire [1:0] level_act = level_mode & level_low;
  wire [1:0] pending = flag | level_act;
  wire [1:0] next_req = pending & line_en & {2{gie}} &
                        {2{next_state == epiu_pkg::ST_RUN}};
  wire idle_wake = |(pending & line_en);
  wire deep_lvl = |(level_act & line_en);

  // Watchdog tick, free running; a stalled clock would still pace wake-up here
  wire wd_tick = (wd_cnt == epiu_pkg::WD_TICK_LAST);
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) wd_cnt <= 8'h00;
    else wd_cnt <= wd_tick ? 8'h00 : wd_cnt + 8'h01;
  end

  // Start-up length from the fuses
  wire [11:0] start_last = (I_STARTUP_TIME_FUSES == 2'h0) ? P_START_TICKS_0 - 12'h001 :
                           (I_STARTUP_TIME_FUSES == 2'h1) ? P_START_TICKS_1 - 12'h001 :
                           (I_STARTUP_TIME_FUSES == 2'h2) ? P_START_TICKS_2 - 12'h001 :
                           P_START_TICKS_3 - 12'h001;
  wire start_end = wd_tick & (start_cnt >= start_last);

  // Sleep and wake sequencing
  always_comb begin
    next_state = state;
    next_commit = commit;
    next_wake = 1'b0;
    case (state)
      epiu_pkg::ST_RUN: begin
        if (sleep_go) next_state = epiu_pkg::ST_SLEEP;
      end
      epiu_pkg::ST_SLEEP: begin
        if (sleep_mode == epiu_pkg::MODE_IDLE) begin
          if (idle_wake) begin
            next_state = epiu_pkg::ST_RUN;
            next_wake = 1'b1;
          end
        end else if (sleep_mode == epiu_pkg::MODE_POWER_DOWN) begin
          if (wd_tick & deep_lvl) next_state = epiu_pkg::ST_SAMPLE;
        end else if (deep_lvl) begin
          next_state = epiu_pkg::ST_STARTUP;
          next_commit = 1'b1;
        end
      end
      epiu_pkg::ST_SAMPLE: begin
        if (wd_tick) begin
          next_state = epiu_pkg::ST_STARTUP;
          next_commit = deep_lvl;
        end
      end
      epiu_pkg::ST_STARTUP: begin
        if (start_end) begin
          // Without a second good sample the level must still be present when start-up ends
          next_state = (commit | deep_lvl) ? epiu_pkg::ST_RUN : epiu_pkg::ST_SLEEP;
          next_wake = commit | deep_lvl;
          next_commit = 1'b0;
        end
      end
      default: begin
        next_state = epiu_pkg::ST_RUN;
        next_commit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state <= epiu_pkg::ST_RUN;
      commit <= 1'b0;
      start_cnt <= 12'h000;
    end else begin
      state <= next_state;
      commit <= next_commit;
      start_cnt <= (state != epiu_pkg::ST_STARTUP) ? 12'h000 : start_cnt + {11'h000, wd_tick};
    end
  end

  // Sticky events; a read clears but a same-cycle event still lands
  wire [2:0] ev = {next_wake, det_event};
  wire [2:0] next_istat = (istat & ~{3{istat_clear}}) | ev;
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      istat <= 3'h0;
      O_IRQ <= 1'b0;
    end else begin
      istat <= next_istat;
      O_IRQ <= |(next_istat & imask);
    end
  end

  // CPU-facing outputs; line A has priority for the vector
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_LINE_REQ <= 2'h0;
      O_VECTOR_VALID <= 1'b0;
      O_VECTOR_LINE <= 1'b0;
      O_IO_CLK_RUN <= 1'b1;
      O_SLEEPING <= 1'b0;
      O_WAKE <= 1'b0;
    end else begin
      O_LINE_REQ <= next_req;
      O_VECTOR_VALID <= |next_req;
      O_VECTOR_LINE <= ~next_req[0];
      O_IO_CLK_RUN <= (next_state == epiu_pkg::ST_RUN) |
                      ((next_state == epiu_pkg::ST_SLEEP) & (next_mode == epiu_pkg::MODE_IDLE));
      O_SLEEPING <= next_state != epiu_pkg::ST_RUN;
      O_WAKE <= next_wake;
    end
  end
  assign O_EXT_LINE_A_PIN = pin_out[0];
  assign O_EXT_LINE_A_PIN_OE = pin_oe[0];
  assign O_EXT_LINE_B_PIN = pin_out[1];
  assign O_EXT_LINE_B_PIN_OE = pin_oe[1];

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RESET_N);

  apb_ready_a: assert property (
    I_PSEL && !I_PENABLE && !pready |=> pready) else $error("no ready after setup");
  level_hold_a: assert property (
    state == epiu_pkg::ST_RUN && sleep_go == 1'b0 && level_act[0] && line_en[0] && gie
    |=> O_LINE_REQ[0]) else $error("level request dropped while pin low");
  gate_en_a: assert property (
    O_LINE_REQ[0] |-> $past(line_en[0] && gie)) else $error("request without enables");
  wd_spacing_a: assert property (
    wd_tick |=> !wd_tick [*8]) else $error("watchdog ticks too close");
  pd_sample_a: assert property (
    state == epiu_pkg::ST_SLEEP && sleep_mode == epiu_pkg::MODE_POWER_DOWN && !wd_tick
    |=> state != epiu_pkg::ST_SAMPLE && state != epiu_pkg::ST_STARTUP)
    else $error("power-down left sleep without watchdog tick");
  lost_level_a: assert property (
    state == epiu_pkg::ST_STARTUP && start_end && commit && !deep_lvl && flag == 2'h0
    |=> O_WAKE && O_LINE_REQ == 2'h0) else $error("wake without level raised request");
  fail_sleep_a: assert property (
    state == epiu_pkg::ST_STARTUP && start_end && !commit && !deep_lvl
    |=> state == epiu_pkg::ST_SLEEP && !O_WAKE) else $error("woke on vanished level");
  io_stop_a: assert property (
    O_SLEEPING && sleep_mode != epiu_pkg::MODE_IDLE |-> !O_IO_CLK_RUN)
    else $error("io clock running in deep sleep");
  irq_out_a: assert property (
    |(istat & imask) && !istat_clear |=> O_IRQ) else $error("unmasked status not signalled");
  loopback_a: assert property (
    pin_oe[0] && !pin_out[0] [*3] |-> level_low[0]) else $error("driven low pin not sensed");

  cov_pd_wake_c: cover property (state == epiu_pkg::ST_SAMPLE ##[1:400] O_WAKE);
  cov_idle_wake_c: cover property (state == epiu_pkg::ST_SLEEP && sleep_mode ==
                                   epiu_pkg::MODE_IDLE ##1 O_WAKE);
  cov_edge_req_c: cover property (flag[1] && O_LINE_REQ[1]);
  cov_istat_rd_c: cover property (istat_clear && istat != 3'h0);
endmodule : epiu_top
`default_nettype wire

// ===== verification/epiu_pin_src.sv
`timescale 1ns/10ps
`default_nettype none
// Far-side sources for both pins; idle high as a pulled-up line would be
module epiu_pin_src (
  input wire logic i_clk,
  output logic [1:0] o_pin
);
  initial o_pin = 2'h3;
  // Holds a level until told otherwise, also across a whole wake-up
  task automatic drive(input int line, input logic val);
    o_pin[line] <= val;
  endtask : drive
  // Pulses always span two clocks, since one clock or less may be missed
  task automatic pulse(input int line, input logic val);
    o_pin[line] <= val;
    repeat (2) @(posedge i_clk);
    o_pin[line] <= ~val;
  endtask : pulse
endmodule : epiu_pin_src
`default_nettype wire

// ===== verification/epiu_tb.sv
`timescale 1ns/10ps
`default_nettype none
module epiu_tb;
  typedef struct packed {logic [1:0] code; logic from_lvl; logic to_lvl; logic flag; logic req;}
    epiu_row_s;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] hent = 2'h0;
  logic [1:0] fuse = 2'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, oa, oa_oe, ob, ob_oe, vvalid, vline, iorun, sleeping, wake, irq, err;
  logic seen;
  logic [1:0] pin, req;
  wire pad_a;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  // Sense code, pin from, pin to, flag expected, request expected
  epiu_row_s rows [8] = '{
    '{epiu_pkg::SENSE_RISE, 1'h0, 1'h1, 1'h1, 1'h1}, '{epiu_pkg::SENSE_RISE, 1'h1, 1'h0, 1'h0, 1'h0},
    '{epiu_pkg::SENSE_FALL, 1'h1, 1'h0, 1'h1, 1'h1}, '{epiu_pkg::SENSE_FALL, 1'h0, 1'h1, 1'h0, 1'h0},
    '{epiu_pkg::SENSE_ANY, 1'h0, 1'h1, 1'h1, 1'h1}, '{epiu_pkg::SENSE_ANY, 1'h1, 1'h0, 1'h1, 1'h1},
    '{epiu_pkg::SENSE_LOW, 1'h1, 1'h0, 1'h0, 1'h1}, '{epiu_pkg::SENSE_LOW, 1'h0, 1'h1, 1'h0, 1'h0}};
  // The pad follows the device while it drives, the source otherwise
  assign pad_a = oa_oe ? oa : pin[0];
  epiu_pin_src src (.i_clk(clk), .o_pin(pin));
  epiu_top #(.P_START_TICKS_0(12'h002), .P_START_TICKS_1(12'h001), .P_START_TICKS_2(12'h001),
    .P_START_TICKS_3(12'h001)) dut (
    .I_MCLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_EXT_LINE_A_PIN(pad_a), .I_EXT_LINE_B_PIN(pin[1]),
    .O_EXT_LINE_A_PIN(oa), .O_EXT_LINE_A_PIN_OE(oa_oe), .O_EXT_LINE_B_PIN(ob),
    .O_EXT_LINE_B_PIN_OE(ob_oe), .I_STARTUP_TIME_FUSES(fuse), .I_HANDLER_ENTER(hent),
    .O_LINE_REQ(req), .O_VECTOR_VALID(vvalid), .O_VECTOR_LINE(vline), .O_IO_CLK_RUN(iorun),
    .O_SLEEPING(sleeping), .O_WAKE(wake), .O_IRQ(irq));
  // Clock and hang guard; the limit is well above the planned run
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // One transfer; an idle edge after it keeps psel from being set twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    // Ends on pready; only the bench timeout ends this wait if pready never comes
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb
  // Wake is a one-cycle pulse, so it is looked at on every edge
  task automatic wait_wake(input int lim);
    seen = 1'h0;
    for (int k = 0; k < lim && seen !== 1'h1; k++) begin
      @(posedge clk);
      seen = wake;
    end
  endtask : wait_wake
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk);
    chk("io clock run", 32'h1, 32'(iorun));
    apb(1'h0, epiu_pkg::ADDR_SENSE, 32'h0);
    chk("sense reset", 32'(epiu_pkg::SENSE_RESET), rd);
    apb(1'h0, epiu_pkg::ADDR_IMASK, 32'h0);
    chk("imask reset", 32'(epiu_pkg::IMASK_RESET), rd);
    apb(1'h1, 8'h40, 32'hffffffff);
    chk("unmapped error", 32'h1, 32'(err));
    apb(1'h0, 8'h40, 32'h0);
    chk("unmapped data", 32'h0, rd);
    // Level request held back until the global enable is set
    apb(1'h1, epiu_pkg::ADDR_ENABLE, 32'hc0);
    src.drive(0, 1'h0);
    repeat (6) @(posedge clk);
    chk("req without global", 32'h0, 32'(req));
    apb(1'h1, epiu_pkg::ADDR_STATUS, 32'h80);
    repeat (2) @(posedge clk);
    chk("req with global", 32'h1, 32'(req));
    src.drive(0, 1'h1);
    // Table of sense codes on each line in turn
    for (int l = 0; l < 2; l++) begin
      for (int i = 0; i < 8; i++) begin
        src.drive(l, rows[i].from_lvl);
        repeat (5) @(posedge clk);
        apb(1'h1, epiu_pkg::ADDR_SENSE, 32'(rows[i].code) << (2 * l));
        apb(1'h1, epiu_pkg::ADDR_FLAG, 32'hc0);
        src.drive(l, rows[i].to_lvl);
        repeat (6) @(posedge clk);
        chk("line req", 32'(rows[i].req), 32'(req[l]));
        chk("vector valid", 32'(rows[i].req), 32'(vvalid));
        if (rows[i].req) chk("vector line", 32'(l), 32'(vline));
        apb(1'h0, epiu_pkg::ADDR_FLAG, 32'h0);
        chk("line flag", 32'(rows[i].flag), 32'(rd[6 + l]));
      end
    end
    // Device drives its own pin low: loopback still requests
    apb(1'h1, epiu_pkg::ADDR_PIN, 32'h32);
    repeat (6) @(posedge clk);
    chk("loopback req", 32'h1, 32'(req));
    chk("pad drive", 32'he, 32'({ob_oe, ob, oa_oe, oa}));
    apb(1'h0, epiu_pkg::ADDR_PIN, 32'h0);
    chk("pin register", 32'h232, rd);
    apb(1'h1, epiu_pkg::ADDR_PIN, 32'h0);
    // Two-clock pulse, masked interrupt, handler entry and write-one clear
    apb(1'h1, epiu_pkg::ADDR_SENSE, 32'hf);
    apb(1'h1, epiu_pkg::ADDR_FLAG, 32'hc0);
    apb(1'h1, epiu_pkg::ADDR_IMASK, 32'h1);
    apb(1'h0, epiu_pkg::ADDR_ISTAT, 32'h0);
    src.pulse(0, 1'h0);
    repeat (6) @(posedge clk);
    chk("irq raised", 32'h1, 32'(irq));
    apb(1'h0, epiu_pkg::ADDR_ISTAT, 32'h0);
    chk("istat event", 32'h1, rd);
    repeat (3) @(posedge clk);
    chk("irq cleared", 32'h0, 32'(irq));
    hent <= 2'h1;
    @(posedge clk);
    hent <= 2'h0;
    repeat (3) @(posedge clk);
    apb(1'h0, epiu_pkg::ADDR_FLAG, 32'h0);
    chk("flag after handler", 32'h0, rd);
    apb(1'h1, epiu_pkg::ADDR_IMASK, 32'h0);
    src.pulse(0, 1'h0);
    repeat (6) @(posedge clk);
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'h1, epiu_pkg::ADDR_FLAG, 32'hc0);
    @(posedge clk);
    chk("req after clear", 32'h0, 32'(req));
    // Idle sleep keeps the I/O clock, so an edge wakes
    apb(1'h1, epiu_pkg::ADDR_SLEEP, 32'h1);
    chk("idle io clock", 32'h1, 32'(iorun));
    chk("idle sleeping", 32'h1, 32'(sleeping));
    src.pulse(0, 1'h0);
    wait_wake(50);
    chk("idle edge wake", 32'h1, 32'(seen));
    // Power-down: edges ignored, held low level wakes and then requests
    apb(1'h1, epiu_pkg::ADDR_FLAG, 32'hc0);
    apb(1'h1, epiu_pkg::ADDR_SLEEP, 32'h3);
    chk("pd io clock", 32'h0, 32'(iorun));
    src.pulse(0, 1'h0);
    wait_wake(600);
    chk("pd edge wake", 32'h0, 32'(seen));
    apb(1'h1, epiu_pkg::ADDR_SENSE, 32'hc);
    src.drive(0, 1'h0);
    wait_wake(1500);
    chk("pd level wake", 32'h1, 32'(seen));
    repeat (6) @(posedge clk);
    chk("req after wake", 32'h1, 32'(req));
    src.drive(0, 1'h1);
    // Level passes double sampling, then leaves before start-up ends
    apb(1'h0, epiu_pkg::ADDR_ISTAT, 32'h0);
    apb(1'h1, epiu_pkg::ADDR_SLEEP, 32'h3);
    src.drive(0, 1'h0);
    repeat (420) @(posedge clk);
    src.drive(0, 1'h1);
    wait_wake(1000);
    chk("lost level wake", 32'h1, 32'(seen));
    repeat (6) @(posedge clk);
    chk("lost level req", 32'h0, 32'(req));
    apb(1'h0, epiu_pkg::ADDR_ISTAT, 32'h0);
    chk("wake status", 32'h1, 32'(rd[epiu_pkg::ISTAT_WAKE_BIT]));
    // Watchdog phase is known from the wake just seen: the low level meets the
    // first power-down sample but is gone by the second, so start-up ends asleep
    apb(1'h1, epiu_pkg::ADDR_SLEEP, 32'h3);
    src.drive(0, 1'h0);
    repeat (250) @(posedge clk);
    src.drive(0, 1'h1);
    wait_wake(700);
    chk("glitch no wake", 32'h0, 32'(seen));
    chk("glitch asleep", 32'h1, 32'(sleeping));
    // Standby goes straight to a start-up of the length the other fuse code picks
    fuse <= 2'h1;
    apb(1'h1, epiu_pkg::ADDR_SLEEP, 32'h6);
    src.drive(0, 1'h0);
    wait_wake(800);
    chk("standby level wake", 32'h1, 32'(seen));
    repeat (6) @(posedge clk);
    chk("standby req", 32'h1, 32'(req));
    src.drive(0, 1'h1);
    stop_test();
  end
endmodule : epiu_tb
`default_nettype wire
